/* hdl/tone_program_loader.sv */
// How it works
// - tones mode reports keypad code in bits 3-0
// - program write clears flag (not in the cycle a settle count ends), set again later
// - powersave or reset reloads tone memory defaults
// - four transmit tone pairs, frequency and level
// - transmit words stored pair by pair in order
// - fourth pair defaults to the alert tones
// - zero frequency and level gives single tone
// - each detector: ten coefficients, then three timings
// - coefficients are 15-bit signed, top bit zero
// - detectors time n cycles against two bounds
// - timing counted in 9.6kHz ticks, bounds inclusive
// - unprogrammed detectors look for the alert tones
// - new receive values apply at next mode entry
// - write-only 16-bit program word at E8h
// - interrupt pin low when irq and enabled
// - status bit 5 marks a valid keypad code
`timescale 1ns/1ns
`default_nettype none
module tone_program_loader #(
  parameter int TICK_DIV_P = tone_prog_pkg::TICK_DIV,
  parameter int DONE_CYC_P = tone_prog_pkg::PROG_DONE_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic powersave_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic cmd_data_in,
  output logic reply_data_out,
  output logic reply_oe_out,
  input wire logic irq_bit_in,
  input wire logic interrupt_output_enable_in,
  output logic irq_n_out,
  output logic irq_oe_out,
  input wire logic rx_tones_mode_in,
  input wire logic [2:0] rx_tone_select_in,
  input wire logic dtmf_valid_in,
  input wire logic [1:0] dtmf_row_in,
  input wire logic [1:0] dtmf_col_in,
  input wire logic [1:0] rx_tone_sign_in,
  input wire logic [4:0] coef_sel_in,
  output logic [14:0] coef_out,
  input wire logic [1:0] tx_pair_sel_in,
  output logic [13:0] tx_freq1_out,
  output logic [13:0] tx_level1_out,
  output logic [13:0] tx_freq2_out,
  output logic [13:0] tx_level2_out,
  output logic tx_tone1_on_out,
  output logic tx_tone2_on_out
);
  import tone_prog_pkg::*;

  logic cs_meta_q, cs_q, sclk_meta_q, sclk_q, sclk_prev_q, cmd_meta_q, cmd_q;
  logic sclk_rise, sclk_fall, clr;
  bus_state_t bus_q;
  logic [3:0] bit_q;
  logic [14:0] shift_q;
  logic [15:0] rd_q;
  logic [15:0] wr_data_q;
  logic wr_q;
  logic gen_reset_q;
  seq_t seq_q;
  logic [4:0] idx_q;
  logic [13:0] tx_mem [TX_WORDS];
  logic [14:0] rx_mem [RX_WORDS];
  logic [14:0] act_mem [RX_WORDS];
  logic flag_q;
  logic [7:0] done_q;
  logic prog_mode, prog_mode_q;
  logic [12:0] tick_cnt_q;
  logic tick_q;
  logic [1:0] det;
  logic [15:0] status_d, status_q;
  logic [3:0] base;

  // the reset pin, reset command or powersave reloads the tone store with its defaults
  assign clr = !rst_n_in || powersave_in || gen_reset_q;
  assign sclk_rise = sclk_q && !sclk_prev_q;
  assign sclk_fall = !sclk_q && sclk_prev_q;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      cs_meta_q <= 1'b1;
      cs_q <= 1'b1;
      sclk_meta_q <= 1'b0;
      sclk_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      cmd_meta_q <= 1'b0;
      cmd_q <= 1'b0;
    end
    else
    begin
      cs_meta_q <= cs_n_in;
      cs_q <= cs_meta_q;
      sclk_meta_q <= sclk_in;
      sclk_q <= sclk_meta_q;
      sclk_prev_q <= sclk_q;
      cmd_meta_q <= cmd_data_in;
      cmd_q <= cmd_meta_q;
    end
  end

  // serial bus slave: address byte, then one 16-bit word in or out, msb first
  always_ff @(posedge clk_sys_in)
  begin
    wr_q <= 1'b0;
    gen_reset_q <= 1'b0;
    if (!rst_n_in || cs_q)
    begin
      bus_q <= BUS_ADDR;
      bit_q <= 4'h0;
      shift_q <= 15'h0000;
      rd_q <= 16'h0000;
      wr_data_q <= 16'h0000;
      reply_data_out <= 1'b0;
      reply_oe_out <= 1'b0;
    end
    else
    begin
      if (sclk_rise)
      begin
        shift_q <= {shift_q[13:0], cmd_q};
        bit_q <= 4'(bit_q + 1'b1);
        case (bus_q)
          BUS_ADDR:
            if (bit_q == 4'(ADDR_BITS - 1))
            begin
              bit_q <= 4'h0;
              case ({shift_q[6:0], cmd_q})
                ADDR_TONE_PROGRAM_WORD: bus_q <= BUS_WRITE;
                ADDR_STATUS:
                begin
                  bus_q <= BUS_READ;
                  rd_q <= status_q;
                end
                ADDR_GEN_RESET:
                begin
                  bus_q <= BUS_SKIP;
                  gen_reset_q <= 1'b1;
                end
                default: bus_q <= BUS_SKIP;
              endcase
            end
          BUS_WRITE:
            if (bit_q == 4'(WORD_BITS - 1))
            begin
              wr_data_q <= {shift_q, cmd_q};
              wr_q <= 1'b1;
              bus_q <= BUS_SKIP;
            end
          default: bus_q <= bus_q;
        endcase
      end
      if (sclk_fall && bus_q == BUS_READ)
      begin
        reply_data_out <= rd_q[15];
        reply_oe_out <= 1'b1;
        rd_q <= {rd_q[14:0], 1'b0};
      end
    end
  end

  // sequence loader: header restarts, words past the end are dropped
  always_ff @(posedge clk_sys_in)
  begin
    if (clr)
    begin
      seq_q <= SEQ_IDLE;
      idx_q <= 5'h00;
      for (int i = 0; i < TX_WORDS; i++)
        tx_mem[i] <= tx_default(i);
      for (int i = 0; i < RX_WORDS; i++)
        rx_mem[i] <= rx_default(i);
    end
    else if (wr_q)
    begin
      if (wr_data_q == HDR_TX)
      begin
        seq_q <= SEQ_TX;
        idx_q <= 5'h00;
      end
      else if (wr_data_q == HDR_RX)
      begin
        seq_q <= SEQ_RX;
        idx_q <= 5'h00;
      end
      else
      begin
        case (seq_q)
          SEQ_TX:
            if (idx_q < 5'(TX_WORDS))
            begin
              tx_mem[idx_q[3:0]] <= wr_data_q[13:0];
              idx_q <= 5'(idx_q + 1'b1);
            end
          SEQ_RX:
            if (idx_q < 5'(RX_WORDS))
            begin
              rx_mem[idx_q] <= wr_data_q[14:0];
              idx_q <= 5'(idx_q + 1'b1);
            end
          default: idx_q <= idx_q;
        endcase
      end
    end
  end

  // the store takes one cycle; the flag is held low a fixed settle time after it, or stays high if the previous count ends in that cycle
  always_ff @(posedge clk_sys_in)
  begin
    if (clr)
    begin
      flag_q <= 1'b1;
      done_q <= 8'h00;
    end
    else
    begin
      if (wr_q)
        done_q <= 8'(DONE_CYC_P);
      else if (done_q != 8'h00)
        done_q <= 8'(done_q - 1'b1);
      if (done_q == 8'h01)
        flag_q <= 1'b1;
      else if (wr_q)
        flag_q <= 1'b0;
    end
  end

  assign prog_mode = rx_tones_mode_in && (rx_tone_select_in == SEL_PROG_TONE);

  // detectors run from a copy taken on mode entry, so live edits wait
  always_ff @(posedge clk_sys_in)
  begin
    if (clr)
    begin
      prog_mode_q <= 1'b0;
      for (int i = 0; i < RX_WORDS; i++)
        act_mem[i] <= rx_default(i);
    end
    else
    begin
      prog_mode_q <= prog_mode;
      if (prog_mode && !prog_mode_q)
        act_mem <= rx_mem;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in || tick_cnt_q == 13'(TICK_DIV_P - 1))
      tick_cnt_q <= 13'h0000;
    else
      tick_cnt_q <= 13'(tick_cnt_q + 1'b1);
    tick_q <= rst_n_in && (tick_cnt_q == 13'(TICK_DIV_P - 1));
  end

  for (genvar gi = 0; gi < 2; gi++)
  begin : g_det
    tone_meter_if #(.W(15)) mif ();
    assign mif.tick = tick_q;
    assign mif.sign_raw = rx_tone_sign_in[gi];
    assign mif.enable = prog_mode_q;
    assign mif.ncyc = act_mem[gi * RX_PER_DET + OFS_NCYC];
    assign mif.tmin = act_mem[gi * RX_PER_DET + OFS_MIN];
    assign mif.tmax = act_mem[gi * RX_PER_DET + OFS_MAX];
    assign det[gi] = mif.detect;
    tone_freq_meter #(.W(15)) u_meter (
      .clk_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .m(mif.meter)
    );
  end

  always_comb
  begin
    status_d = 16'h0000;
    status_d[STAT_IRQ] = irq_bit_in;
    status_d[STAT_FLAG] = flag_q;
    if (rx_tones_mode_in && dtmf_valid_in)
    begin
      status_d[STAT_DTMF] = 1'b1;
      status_d[3:0] = dtmf_code(dtmf_row_in, dtmf_col_in);
    end
    if (prog_mode_q)
    begin
      status_d[STAT_FIRST] = det[0];
      status_d[STAT_SECOND] = det[1];
      status_d[STAT_BOTH] = &det;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (clr)
      status_q <= 16'h0000;
    else
      status_q <= status_d;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      irq_n_out <= 1'b1;
      irq_oe_out <= 1'b0;
    end
    else
    begin
      irq_n_out <= !(irq_bit_in && interrupt_output_enable_in);
      irq_oe_out <= irq_bit_in && interrupt_output_enable_in;
    end
  end

  assign base = {tx_pair_sel_in, 2'b00};

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      tx_freq1_out <= 14'h0000;
      tx_level1_out <= 14'h0000;
      tx_freq2_out <= 14'h0000;
      tx_level2_out <= 14'h0000;
      tx_tone1_on_out <= 1'b0;
      tx_tone2_on_out <= 1'b0;
      coef_out <= 15'h0000;
    end
    else
    begin
      tx_freq1_out <= tx_mem[base];
      tx_level1_out <= tx_mem[4'(base + 4'h1)];
      tx_freq2_out <= tx_mem[4'(base + 4'h2)];
      tx_level2_out <= tx_mem[4'(base + 4'h3)];
      tx_tone1_on_out <= (tx_mem[base] | tx_mem[4'(base + 4'h1)]) != 14'h0000;
      tx_tone2_on_out <= (tx_mem[4'(base + 4'h2)] | tx_mem[4'(base + 4'h3)]) != 14'h0000;
      coef_out <= (coef_sel_in < 5'(RX_WORDS)) ? act_mem[coef_sel_in] : 15'h0000;
    end
  end
endmodule
`default_nettype wire

/* hdl/tone_prog_pkg.sv */
package tone_prog_pkg;
  // serial control bus addresses
  localparam logic [7:0] ADDR_GEN_RESET = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'hE6;
  localparam logic [7:0] ADDR_TONE_PROGRAM_WORD = 8'hE8;
  localparam int ADDR_BITS = 8;
  localparam int WORD_BITS = 16;
  // programming sequence headers
  localparam logic [15:0] HDR_TX = 16'h8000;
  localparam logic [15:0] HDR_RX = 16'h8001;
  localparam int TX_WORDS = 16;
  localparam int RX_WORDS = 26;
  localparam int RX_PER_DET = 13;
  localparam int RX_COEFS = 10;
  localparam int OFS_NCYC = 10;
  localparam int OFS_MIN = 11;
  localparam int OFS_MAX = 12;
  // status register bit positions
  localparam int STAT_IRQ = 15;
  localparam int STAT_FLAG = 13;
  localparam int STAT_BOTH = 10;
  localparam int STAT_SECOND = 7;
  localparam int STAT_FIRST = 6;
  localparam int STAT_DTMF = 5;
  localparam logic [2:0] SEL_PROG_TONE = 3'h4;
  // timing
  localparam int CLK_HZ = 50000000;
  localparam int TIMER_HZ = 9600;
  localparam int TICK_DIV = CLK_HZ / TIMER_HZ;
  localparam int PROG_DONE_NS = 2000;
  localparam int PROG_MAX_NS = 150000;
  localparam int PROG_DONE_CYC = (PROG_DONE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // default fourth transmit pair: alert tones, level at -20 dBm with a 3.0 V analog_supply
  localparam logic [13:0] TX_DEF_FREQ1 = 14'h1C68;
  localparam logic [13:0] TX_DEF_FREQ2 = 14'h24AD;
  localparam logic [13:0] TX_DEF_LEVEL = 14'h0977;
  // default detectors: 64 cycles, 2130 +-20 Hz and 2750 +-20 Hz
  localparam logic [14:0] RX_DEF_NCYC = 15'h0040;
  localparam logic [14:0] RX1_DEF_MIN = 15'h011E;
  localparam logic [14:0] RX1_DEF_MAX = 15'h0123;
  localparam logic [14:0] RX2_DEF_MIN = 15'h00DE;
  localparam logic [14:0] RX2_DEF_MAX = 15'h00E1;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_TX = 3'b010,
    SEQ_RX = 3'b100
  } seq_t;

  typedef enum logic [3:0] {
    BUS_ADDR = 4'b0001,
    BUS_WRITE = 4'b0010,
    BUS_READ = 4'b0100,
    BUS_SKIP = 4'b1000
  } bus_state_t;

  // row 697/770/852/941, column 1209/1336/1477/1633
  function automatic logic [3:0] dtmf_code(input logic [1:0] row, input logic [1:0] col);
    logic [3:0] c;
    c = 4'h0;
    if (col == 2'h3)
      c = (row == 2'h3) ? 4'h0 : 4'(4'hD + {2'h0, row});
    else if (row == 2'h3)
      c = (col == 2'h0) ? 4'hB : ((col == 2'h1) ? 4'hA : 4'hC);
    else
      c = 4'(row * 3 + col + 1);
    return c;
  endfunction

  function automatic logic [13:0] tx_default(input int i);
    logic [13:0] v;
    v = 14'h0000;
    if (i == 12)
      v = TX_DEF_FREQ1;
    else if (i == 14)
      v = TX_DEF_FREQ2;
    else if (i == 13 || i == 15)
      v = TX_DEF_LEVEL;
    return v;
  endfunction

  function automatic logic [14:0] rx_default(input int i);
    logic [14:0] v;
    v = 15'h0000;
    case (i)
      OFS_NCYC, RX_PER_DET + OFS_NCYC: v = RX_DEF_NCYC;
      OFS_MIN: v = RX1_DEF_MIN;
      OFS_MAX: v = RX1_DEF_MAX;
      RX_PER_DET + OFS_MIN: v = RX2_DEF_MIN;
      RX_PER_DET + OFS_MAX: v = RX2_DEF_MAX;
      default: v = 15'h0000;
    endcase
    return v;
  endfunction
endpackage

/* hdl/tone_meter_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface tone_meter_if #(parameter int W = 15);
  logic tick;
  logic sign_raw;
  logic enable;
  logic [W-1:0] ncyc;
  logic [W-1:0] tmin;
  logic [W-1:0] tmax;
  logic detect;
  modport meter(input tick, sign_raw, enable, ncyc, tmin, tmax, output detect);
  modport ctrl(output tick, sign_raw, enable, ncyc, tmin, tmax, input detect);
endinterface
`default_nettype wire

/* hdl/tone_freq_meter.sv */
`timescale 1ns/1ns
`default_nettype none
module tone_freq_meter #(parameter int W = 15) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  tone_meter_if.meter m
);
  logic sign_meta_q;
  logic sign_q;
  logic sign_prev_q;
  logic started_q;
  logic [W-1:0] cyc_q;
  logic [W-1:0] time_q;
  logic det_q;
  logic rise;

  assign rise = sign_q && !sign_prev_q;
  assign m.detect = det_q;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      sign_meta_q <= 1'b0;
      sign_q <= 1'b0;
      sign_prev_q <= 1'b0;
    end
    else
    begin
      sign_meta_q <= m.sign_raw;
      sign_q <= sign_meta_q;
      sign_prev_q <= sign_q;
    end
  end

  // the window opens on one rising edge and closes ncyc edges later
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !m.enable)
    begin
      started_q <= 1'b0;
      cyc_q <= '0;
      time_q <= '0;
      det_q <= 1'b0;
    end
    else if (rise)
    begin
      if (!started_q)
      begin
        started_q <= 1'b1;
        cyc_q <= '0;
        time_q <= '0;
      end
      else if (W'(cyc_q + 1'b1) >= m.ncyc)
      begin
        det_q <= (time_q >= m.tmin) && (time_q <= m.tmax);
        cyc_q <= '0;
        time_q <= '0;
      end
      else
      begin
        cyc_q <= W'(cyc_q + 1'b1);
        // time runs across all ncyc cycles, not only the last one
        if (m.tick && time_q != '1)
          time_q <= W'(time_q + 1'b1);
      end
    end
    else
    begin
      if (m.tick && time_q != '1)
        time_q <= W'(time_q + 1'b1);
      // a tone that stops leaves the window open; time out rather than hold detect
      if (time_q > m.tmax)
        det_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* dv/tone_program_loader_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module tone_program_loader_monitor
  import tone_prog_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic powersave_in,
  input wire logic cs_n_in,
  input wire logic reply_oe_out,
  input wire logic irq_bit_in,
  input wire logic interrupt_output_enable_in,
  input wire logic irq_n_out,
  input wire logic irq_oe_out,
  input wire logic rx_tones_mode_in,
  input wire logic [2:0] rx_tone_select_in,
  input wire logic [4:0] coef_sel_in,
  input wire logic [14:0] coef_out,
  input wire logic [1:0] tx_pair_sel_in,
  input wire logic [13:0] tx_freq1_out,
  input wire logic [13:0] tx_level1_out,
  input wire logic [13:0] tx_freq2_out,
  input wire logic [13:0] tx_level2_out,
  input wire logic tx_tone1_on_out,
  input wire logic tx_tone2_on_out
);
  wire logic irq_req = irq_bit_in && interrupt_output_enable_in;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  // table select must hold too, else coef_out legitimately moves
  sequence prog_run_s;
    rx_tones_mode_in && rx_tone_select_in == SEL_PROG_TONE && !powersave_in
      && $stable(coef_sel_in);
  endsequence
  sequence bus_quiet_s;
    cs_n_in && !powersave_in && $stable(tx_pair_sel_in);
  endsequence
  irq_drive_a:
    assert property ($past(rst_n_in) |-> irq_oe_out == $past(irq_req))
    else $error("irq pin enable not following irq and enable");
  irq_pin_a:
    assert property (irq_oe_out |-> !irq_n_out)
    else $error("irq pin enabled but not low");
  tone1_on_a:
    assert property (tx_tone1_on_out == (tx_freq1_out != 14'h0000 || tx_level1_out != 14'h0000))
    else $error("tone 1 on flag wrong");
  tone2_on_a:
    assert property (tx_tone2_on_out == (tx_freq2_out != 14'h0000 || tx_level2_out != 14'h0000))
    else $error("tone 2 on flag wrong");
  coef_range_a:
    assert property (coef_sel_in > 5'h19 |=> coef_out == 15'h0000)
    else $error("coefficient index past table not zero");
  ps_default_a:
    assert property ((powersave_in && tx_pair_sel_in == 2'h3)[*3]
      |-> tx_freq1_out == TX_DEF_FREQ1 && tx_freq2_out == TX_DEF_FREQ2)
    else $error("fourth pair not at defaults in powersave");
  reply_off_a:
    assert property (cs_n_in[*5] |-> !reply_oe_out)
    else $error("reply driven with bus deselected");
  tx_hold_a:
    assert property (bus_quiet_s[*4] |=> $stable(tx_freq1_out) && $stable(tx_level2_out))
    else $error("transmit words moved without a bus write");
  coef_hold_a:
    assert property (prog_run_s[*4] |=> $stable(coef_out))
    else $error("active detector table changed inside the mode");
endmodule
`default_nettype wire

/* dv/tone_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module tone_host_model (
  input wire logic clk_in,
  input wire logic reply_data_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic cmd_data_out
);
  import tone_prog_pkg::*;
  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    cmd_data_out = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge clk_in);
  endtask
  // address then data, msb first; the last 16 sampled reply bits land in q
  task automatic xfer(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    logic [23:0] sh;
    sh = {a, d};
    q = 16'h0000;
    @(negedge clk_in);
    cs_n_out = 1'b0;
    half();
    for (int i = 0; i < 24; i++)
    begin
      cmd_data_out = sh[23 - i];
      half();
      q = {q[14:0], reply_data_in};
      sclk_out = 1'b1;
      half();
      sclk_out = 1'b0;
    end
    half();
    cs_n_out = 1'b1;
    // released line shows the opposite level so a stale bit is never trusted
    cmd_data_out = ~cmd_data_out;
    repeat (60) @(negedge clk_in);
  endtask
  // only status and program addresses are used, never the reserved ones
  task automatic prog(input logic [15:0] w, output logic ok);
    logic [15:0] st;
    ok = 1'b0;
    for (int n = 0; n < 40 && !ok; n++)
    begin
      xfer(ADDR_STATUS, 16'h0000, st);
      ok = st[STAT_FLAG];
    end
    xfer(ADDR_TONE_PROGRAM_WORD, w, st);
  endtask
endmodule
`default_nettype wire

/* dv/tone_program_loader_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tone_program_loader_tb;
  import tone_prog_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ps = 1'b0, irq_bit = 1'b0, irq_en = 1'b0;
  logic tmode = 1'b0, dval = 1'b0, ok, cs_n, sclk, cmd, reply, reply_oe, irq_n, irq_oe;
  logic t1on, t2on;
  logic [2:0] tsel = 3'h1;
  logic [1:0] row = 2'h0, col = 2'h0, sign = 2'h0, psel = 2'h0;
  logic [4:0] csel = 5'h00;
  logic [14:0] coef;
  logic [13:0] f1, l1, f2, l2;
  logic [15:0] st;
  logic [3:0] key_code [16] = '{4'h1, 4'h2, 4'h3, 4'hD, 4'h4, 4'h5, 4'h6, 4'hE,
    4'h7, 4'h8, 4'h9, 4'hF, 4'hB, 4'hA, 4'hC, 4'h0};
  int err_count = 0, tests_run = 0;
  always #10 clk = ~clk;
  // detector input toggles on falling edges, slow beside the timer tick
  always #1040 sign = ~sign;
  tone_program_loader #(.TICK_DIV_P(8), .DONE_CYC_P(200)) tone_program_loader_inst (
    .clk_sys_in(clk), .rst_n_in(rst_n), .powersave_in(ps), .cs_n_in(cs_n), .sclk_in(sclk),
    .cmd_data_in(cmd), .reply_data_out(reply), .reply_oe_out(reply_oe), .irq_bit_in(irq_bit),
    .interrupt_output_enable_in(irq_en), .irq_n_out(irq_n), .irq_oe_out(irq_oe),
    .rx_tones_mode_in(tmode), .rx_tone_select_in(tsel), .dtmf_valid_in(dval),
    .dtmf_row_in(row), .dtmf_col_in(col), .rx_tone_sign_in(sign), .coef_sel_in(csel),
    .coef_out(coef), .tx_pair_sel_in(psel), .tx_freq1_out(f1), .tx_level1_out(l1),
    .tx_freq2_out(f2), .tx_level2_out(l2), .tx_tone1_on_out(t1on), .tx_tone2_on_out(t2on));
  tone_host_model tone_host_model_inst (.clk_in(clk), .reply_data_in(reply),
    .cs_n_out(cs_n), .sclk_out(sclk), .cmd_data_out(cmd));
  function automatic logic [13:0] txw(input int i);
    // top bit clear keeps every frequency code below the 3.4 kHz limit
    return (i == 2 || i == 3) ? 14'h0000 : {1'b0, 4'(i), 9'h155};
  endfunction
  // timing words: 4 cycles of the bench tone take about 52 ticks, inside 40..60
  function automatic logic [14:0] rxw(input int i);
    case (i % RX_PER_DET)
      OFS_NCYC: return 15'h0004;
      OFS_MIN: return 15'h0028;
      OFS_MAX: return 15'h003C;
      default: return {5'(i), 10'h2A5};
    endcase
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic [15:0] d);
    tone_host_model_inst.xfer(a, d, st);
  endtask
  task automatic put(input logic [15:0] w);
    tone_host_model_inst.prog(w, ok);
    chk("flag_back", 16'h0001, {15'h0000, ok});
  endtask
  task automatic tx_chk(input logic [1:0] p, input logic [13:0] a, b, c, d);
    psel = p;
    repeat (3) @(negedge clk);
    chk("tx_freq1", {2'b00, a}, {2'b00, f1});
    chk("tx_level1", {2'b00, b}, {2'b00, l1});
    chk("tx_freq2", {2'b00, c}, {2'b00, f2});
    chk("tx_level2", {2'b00, d}, {2'b00, l2});
  endtask
  task automatic coef_chk(input logic [4:0] i, input logic [14:0] v);
    csel = i;
    repeat (3) @(negedge clk);
    chk("coef", {1'b0, v}, {1'b0, coef});
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    tx_chk(2'h3, TX_DEF_FREQ1, TX_DEF_LEVEL, TX_DEF_FREQ2, TX_DEF_LEVEL);
    tx_chk(2'h0, 14'h0000, 14'h0000, 14'h0000, 14'h0000);
    chk("tone1_on", 16'h0000, {15'h0000, t1on});
    coef_chk(5'd10, RX_DEF_NCYC);
    coef_chk(5'd24, RX2_DEF_MIN);
    $display("test reset done");
    tmode = 1'b1;
    dval = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      row = 2'(i >> 2);
      col = 2'(i);
      bus(ADDR_STATUS, 16'h0000);
      chk("dtmf_status", {12'h202, key_code[i]}, st & 16'hA02F);
    end
    dval = 1'b0;
    bus(ADDR_STATUS, 16'h0000);
    chk("dtmf_valid", 16'h0000, {15'h0000, st[STAT_DTMF]});
    $display("test keypad codes done");
    irq_bit = 1'b1;
    irq_en = 1'b1;
    repeat (3) @(negedge clk);
    chk("irq_pin", 16'h0000, {15'h0000, irq_n});
    irq_en = 1'b0;
    repeat (3) @(negedge clk);
    chk("irq_oe", 16'h0000, {15'h0000, irq_oe});
    irq_bit = 1'b0;
    $display("test irq pin done");
    tmode = 1'b0;
    put(HDR_TX);
    put(16'h0D56);
    put(HDR_TX);
    for (int i = 0; i < TX_WORDS; i++)
      put({2'b00, txw(i)});
    put(16'h2222);
    bus(ADDR_STATUS, 16'h0000);
    chk("flag_low", 16'h0000, {15'h0000, st[STAT_FLAG]});
    bus(8'h55, 16'h1111);
    for (int p = 0; p < 4; p++)
    begin
      tx_chk(2'(p), txw(4 * p), txw(4 * p + 1), txw(4 * p + 2), txw(4 * p + 3));
      chk("tone2_on", 16'(p != 0), {15'h0000, t2on});
    end
    $display("test transmit programming done");
    put(HDR_RX);
    for (int i = 0; i < RX_WORDS; i++)
      put({1'b0, rxw(i)});
    repeat (250) @(negedge clk);
    tsel = SEL_PROG_TONE;
    tmode = 1'b1;
    for (int i = 0; i < RX_WORDS; i++)
      coef_chk(5'(i), rxw(i));
    coef_chk(5'd26, 15'h0000);
    put(HDR_RX);
    put(16'h1234);
    repeat (250) @(negedge clk);
    coef_chk(5'd0, rxw(0));
    bus(ADDR_STATUS, 16'h0000);
    chk("tone_detect", 16'h04C0, st & 16'h04C0);
    tmode = 1'b0;
    repeat (3) @(negedge clk);
    tmode = 1'b1;
    coef_chk(5'd0, 15'h1234);
    $display("test receive programming done");
    // leave the mode first; a general reset reloads the active table whether inside the mode or not
    tmode = 1'b0;
    bus(ADDR_GEN_RESET, 16'h0000);
    tx_chk(2'h1, 14'h0000, 14'h0000, 14'h0000, 14'h0000);
    $display("test general reset done");
    ps = 1'b1;
    tx_chk(2'h0, 14'h0000, 14'h0000, 14'h0000, 14'h0000);
    tx_chk(2'h3, TX_DEF_FREQ1, TX_DEF_LEVEL, TX_DEF_FREQ2, TX_DEF_LEVEL);
    ps = 1'b0;
    tmode = 1'b0;
    repeat (3) @(negedge clk);
    tmode = 1'b1;
    coef_chk(5'd0, 15'h0000);
    coef_chk(5'd11, RX1_DEF_MIN);
    $display("test powersave done");
    report_and_stop();
  end
  initial
  begin
    // the sequence needs about half of this span
    repeat (100000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule
bind tone_program_loader tone_program_loader_monitor tone_program_loader_monitor_inst (
  .clk_sys_in, .rst_n_in, .powersave_in, .cs_n_in, .reply_oe_out, .irq_bit_in,
  .interrupt_output_enable_in, .irq_n_out, .irq_oe_out, .rx_tones_mode_in,
  .rx_tone_select_in, .coef_sel_in, .coef_out, .tx_pair_sel_in, .tx_freq1_out,
  .tx_level1_out, .tx_freq2_out, .tx_level2_out, .tx_tone1_on_out, .tx_tone2_on_out);
`default_nettype wire
